/* File: tpr_host_model.sv */
// Purpose: serial link master standing in for the host controller
// Assumes: mode 0 link, 16-bit words, 125 ns link clock
// Notes:   link clock stands still between words
`timescale 1ns/100ps
module tpr_host_model (
  // serial link
  output logic      link_sclk_out,
  output logic      link_cs_n_out,
  output logic      link_mosi_out,
  input wire logic  link_miso_in,
  input wire logic  link_miso_oe_in
);
  // ----------------------------------------------------------------------
  // word transfer
  // ----------------------------------------------------------------------
  initial begin
    link_sclk_out = 1'b0;
    link_cs_n_out = 1'b1;
    link_mosi_out = 1'b0;
  end
  task automatic xfer(input logic [15:0] word, output logic [15:0] resp);
    #3.3;
    link_cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_mosi_out = word[i];
      #62.5;
      resp[i] = link_miso_oe_in ? link_miso_in : 1'bx;
      link_sclk_out = 1'b1;
      #62.5;
      link_sclk_out = 1'b0;
    end
    #62.5;
    link_cs_n_out = 1'b1;
    link_mosi_out = ~word[0];
    // gap before next word lets the answer settle
    #150;
  endtask : xfer
endmodule : tpr_host_model

/* File: tpr_pkg.sv */
// Purpose: constants and types for the pixel frame serial readout block
// Assumes: 16-bit serial command words, 8-bit registers on pages
// Notes:   command encodings and reserved pixel codes live here
package tpr_pkg;

  // ----------------------------------------------------------------------
  // geometry and word sizes
  // ----------------------------------------------------------------------
  localparam int unsigned PIXEL_W      = 12;
  localparam int unsigned PIXEL_COUNT  = 64;
  localparam int unsigned ROW_COUNT    = 8;
  localparam int unsigned PAIRS_PER_ROW = 4;
  localparam int unsigned BYTES_PER_PAIR = 3;
  localparam int unsigned WORD_W       = 16;

  // ----------------------------------------------------------------------
  // command word first byte
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE_MASK  = 8'h80;
  localparam logic [7:0] CMD_WRITE_MASK = 8'h40;
  localparam logic [7:0] CMD_READ_MASK  = 8'h20;
  localparam logic [15:0] WORD_NOP      = 16'h0000;
  localparam logic [15:0] WORD_BUSY     = 16'hffff;

  // ----------------------------------------------------------------------
  // pages and register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] PAGE_1 = 3'h1;
  localparam logic [2:0] PAGE_2 = 3'h2;
  localparam logic [2:0] PAGE_4 = 3'h4;
  localparam logic [2:0] PAGE_5 = 3'h5;
  localparam logic [4:0] OFS_DEFAULT_ADJUST_C   = 5'h08;
  localparam logic [4:0] OFS_DEFAULT_ADJUST_B   = 5'h0b;
  localparam logic [4:0] OFS_PIXEL_PAIR_BYTE    = 5'h0c;
  localparam logic [4:0] OFS_SATURATION_HI      = 5'h0d;
  localparam logic [4:0] OFS_SATURATION_LO      = 5'h0e;
  localparam logic [4:0] OFS_OVERFLOW_HI        = 5'h10;
  localparam logic [4:0] OFS_OVERFLOW_LO        = 5'h11;
  localparam logic [4:0] OFS_UNDERFLOW_HI       = 5'h12;
  localparam logic [4:0] OFS_UNDERFLOW_LO       = 5'h13;
  localparam logic [4:0] OFS_STATUS             = 5'h15;
  localparam logic [4:0] OFS_MODULATION_SELECT  = 5'h12;
  localparam logic [4:0] OFS_READOUT_MODE       = 5'h15;
  localparam logic [4:0] OFS_DEFAULT_ADJUST_A   = 5'h1a;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_EMBED_OFF_BIT  = 6;
  localparam int unsigned STATUS_DATA_RDY_BIT = 0;
  localparam logic [7:0] RST_REG8             = 8'h00;

  // ----------------------------------------------------------------------
  // reserved pixel codes
  // ----------------------------------------------------------------------
  localparam logic [11:0] CODE_SATURATED = 12'h7ff;
  localparam logic [11:0] CODE_OVERFLOW  = 12'h7fe;
  localparam logic [11:0] CODE_UNDERFLOW = 12'h800;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ      = 100;
  localparam int unsigned STARTUP_US     = 100;
  localparam int unsigned STARTUP_CYCLES = STARTUP_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    TPR_FLAG_NONE      = 2'b00,
    TPR_FLAG_SATURATED = 2'b01,
    TPR_FLAG_OVERFLOW  = 2'b10,
    TPR_FLAG_UNDERFLOW = 2'b11
  } tpr_flag_type;

endpackage : tpr_pkg

/* File: tpr_readout.sv */
// Purpose: serial command slave and frame readout of an 8x8 pixel imager
// Assumes: mode 0 serial link, 16-bit words, chip select active low
// Notes:   link logic runs on the serial clock; commands act on clock_in
`timescale 1ns/100ps

module tpr_readout
  import tpr_pkg::*;
#(
  parameter int unsigned STARTUP_LEN = STARTUP_CYCLES
) (
  // system
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  // serial link
  input  wire logic                link_sclk_in,
  input  wire logic                link_cs_n_in,
  input  wire logic                link_mosi_in,
  output logic                     link_miso_out,
  output logic                     link_miso_oe_out,
  // acquisition side
  input  wire logic                pixel_we_in,
  input  wire logic [5:0]          pixel_addr_in,
  input  wire logic [PIXEL_W-1:0]  pixel_data_in,
  input  wire tpr_pkg::tpr_flag_type pixel_flag_in,
  input  wire logic                frame_done_in,
  input  wire logic [15:0]         saturation_detail_in,
  input  wire logic [15:0]         overflow_detail_in,
  input  wire logic [15:0]         underflow_detail_in,
  // settings seen by the rest of the chip
  output logic [7:0]               default_adjust_a_out,
  output logic [7:0]               default_adjust_b_out,
  output logic [7:0]               default_adjust_c_out,
  output logic [7:0]               modulation_select_out,
  output logic [7:0]               grayscale_imager_setting_out,
  output logic                     frame_ready_out
);
  import tpr_pkg::*;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // centre-out row order
  function automatic logic [2:0] row_of_step(input logic [2:0] step);
    logic [2:0] row;
    unique case (step)
      3'd0: row = 3'd3;
      3'd1: row = 3'd4;
      3'd2: row = 3'd2;
      3'd3: row = 3'd5;
      3'd4: row = 3'd1;
      3'd5: row = 3'd6;
      3'd6: row = 3'd0;
      3'd7: row = 3'd7;
    endcase
    return row;
  endfunction : row_of_step

  // replace a flagged pixel by its reserved code when embedding
  function automatic logic [PIXEL_W-1:0] pixel_out(input logic [PIXEL_W-1:0] raw,
                                                   input tpr_flag_type   flag,
                                                   input logic           embed);
    logic [PIXEL_W-1:0] value;
    value = raw;
    if (embed) begin
      unique case (flag)
        TPR_FLAG_NONE:      value = raw;
        TPR_FLAG_SATURATED: value = CODE_SATURATED;
        TPR_FLAG_OVERFLOW:  value = CODE_OVERFLOW;
        TPR_FLAG_UNDERFLOW: value = CODE_UNDERFLOW;
      endcase
    end
    return value;
  endfunction : pixel_out

  // ----------------------------------------------------------------------
  // link domain: shift words in and out
  // ----------------------------------------------------------------------
  logic              link_rst_n;
  logic [3:0]        bit_cnt;
  logic [14:0]       rx_shift;
  logic [WORD_W-1:0] rx_word;
  logic              rx_toggle;
  logic [WORD_W-1:0] tx_word;
  logic              started;
  logic              miso_q;
  logic [WORD_W-1:0] resp_word;

  // chip select high clears the word position
  assign link_rst_n = rst_n_in & ~link_cs_n_in;

  always_ff @(posedge link_sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt  <= 4'h0;
      rx_shift <= 15'h0000;
    end else begin
      bit_cnt  <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[13:0], link_mosi_in};
    end
  end

  // word complete: hand over by toggle; survives chip select release
  always_ff @(posedge link_sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word   <= 16'h0000;
      rx_toggle <= 1'b0;
    end else if (bit_cnt == 4'hf) begin
      rx_word   <= {rx_shift, link_mosi_in};
      rx_toggle <= ~rx_toggle;
    end
  end

  // answer is settled long before the next word starts
  always_ff @(posedge link_sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_word <= 16'h0000;
    end else if (bit_cnt == 4'h0) begin
      tx_word <= resp_word;
    end
  end

  // bit 15 stays on the pin until the first falling edge shifts bit 14
  always_ff @(negedge link_sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_q  <= 1'b0;
      started <= 1'b0;
    end else begin
      miso_q  <= tx_word[4'hf - bit_cnt];
      started <= 1'b1;
    end
  end

  assign link_miso_out    = started ? miso_q : resp_word[WORD_W-1];
  assign link_miso_oe_out = ~link_cs_n_in;

  // ----------------------------------------------------------------------
  // crossing into the system domain
  // ----------------------------------------------------------------------
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_seen;
  logic       word_strobe;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_meta <= rx_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  assign word_strobe = tog_sync ^ tog_seen;

  // ----------------------------------------------------------------------
  // start-up: busy until the idle answer may be given
  // ----------------------------------------------------------------------
  logic [$clog2(STARTUP_LEN+1)-1:0] start_cnt;
  logic                             idle;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_cnt <= '0;
      idle      <= 1'b0;
    end else if (!idle) begin
      start_cnt <= start_cnt + 1'b1;
      idle      <= (start_cnt == ($clog2(STARTUP_LEN+1))'(STARTUP_LEN - 1));
    end
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  logic [7:0] cmd;
  logic [7:0] cmd_val;
  logic       is_page;
  logic       is_write;
  logic       is_read;
  logic [4:0] cmd_ofs;
  logic [2:0] page;

  assign cmd      = rx_word[15:8];
  assign cmd_val  = rx_word[7:0];
  assign cmd_ofs  = cmd[4:0];
  assign is_page  = word_strobe && idle && (cmd & CMD_PAGE_MASK) != 8'h00;
  assign is_write = word_strobe && idle && cmd[7:5] == CMD_WRITE_MASK[7:5];
  assign is_read  = word_strobe && idle && cmd[7:5] == CMD_READ_MASK[7:5];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page <= 3'h0;
    end else if (is_page) begin
      page <= cmd[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // writable settings
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      default_adjust_a_out         <= RST_REG8;
      default_adjust_b_out         <= RST_REG8;
      default_adjust_c_out         <= RST_REG8;
      modulation_select_out        <= RST_REG8;
      grayscale_imager_setting_out <= RST_REG8;
    end else if (is_write) begin
      if (page == PAGE_1 && cmd_ofs == OFS_DEFAULT_ADJUST_A) begin
        default_adjust_a_out <= cmd_val;
      end
      if (page == PAGE_5 && cmd_ofs == OFS_DEFAULT_ADJUST_B) begin
        default_adjust_b_out <= cmd_val;
      end
      if (page == PAGE_4 && cmd_ofs == OFS_DEFAULT_ADJUST_C) begin
        default_adjust_c_out <= cmd_val;
      end
      if (page == PAGE_4 && cmd_ofs == OFS_MODULATION_SELECT) begin
        modulation_select_out <= cmd_val;
      end
      if (page == PAGE_4 && cmd_ofs == OFS_READOUT_MODE) begin
        grayscale_imager_setting_out <= cmd_val;
      end
    end
  end

  logic embed_on;
  assign embed_on = ~grayscale_imager_setting_out[MODE_EMBED_OFF_BIT];

  // ----------------------------------------------------------------------
  // frame store
  // ----------------------------------------------------------------------
  logic [PIXEL_W-1:0] pix_raw  [PIXEL_COUNT];
  tpr_flag_type       pix_flag [PIXEL_COUNT];

  for (genvar i = 0; i < PIXEL_COUNT; i++) begin : g_pix
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pix_raw[i]  <= '0;
        pix_flag[i] <= TPR_FLAG_NONE;
      end else if (pixel_we_in && pixel_addr_in == 6'(i)) begin
        pix_raw[i]  <= pixel_data_in;
        pix_flag[i] <= pixel_flag_in;
      end
    end
  end

  logic [15:0] sat_detail;
  logic [15:0] ovf_detail;
  logic [15:0] unf_detail;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sat_detail <= 16'h0000;
      ovf_detail <= 16'h0000;
      unf_detail <= 16'h0000;
    end else if (frame_done_in) begin
      sat_detail <= saturation_detail_in;
      ovf_detail <= overflow_detail_in;
      unf_detail <= underflow_detail_in;
    end
  end

  // ----------------------------------------------------------------------
  // readout position and frame ready flag
  // ----------------------------------------------------------------------
  logic [1:0] byte_idx;
  logic [1:0] pair_idx;
  logic [2:0] row_step;
  logic       pixel_read;
  logic       last_read;

  assign pixel_read = is_read && page == PAGE_2 && cmd_ofs == OFS_PIXEL_PAIR_BYTE;
  assign last_read  = pixel_read && byte_idx == 2'd2 && pair_idx == 2'd3 &&
                      row_step == 3'd7;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_idx <= 2'd0;
      pair_idx <= 2'd0;
      row_step <= 3'd0;
    end else if (frame_done_in) begin
      byte_idx <= 2'd0;
      pair_idx <= 2'd0;
      row_step <= 3'd0;
    end else if (pixel_read) begin
      if (byte_idx == 2'd2) begin
        byte_idx <= 2'd0;
        pair_idx <= pair_idx + 2'd1;
        if (pair_idx == 2'd3) begin
          row_step <= row_step + 3'd1;
        end
      end else begin
        byte_idx <= byte_idx + 2'd1;
      end
    end
  end

  // a new frame wins over the clear by the last read
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_ready_out <= 1'b0;
    end else if (frame_done_in) begin
      frame_ready_out <= 1'b1;
    end else if (last_read) begin
      frame_ready_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read data and answer word
  // ----------------------------------------------------------------------
  logic [5:0]         even_addr;
  logic [5:0]         odd_addr;
  logic [PIXEL_W-1:0] even_pix;
  logic [PIXEL_W-1:0] odd_pix;
  logic [7:0]         pair_byte;
  logic [7:0]         read_data;

  assign even_addr = {row_of_step(row_step), pair_idx, 1'b0};
  assign odd_addr  = {row_of_step(row_step), pair_idx, 1'b1};
  assign even_pix  = pixel_out(pix_raw[even_addr], pix_flag[even_addr], embed_on);
  assign odd_pix   = pixel_out(pix_raw[odd_addr], pix_flag[odd_addr], embed_on);

  always_comb begin
    unique case (byte_idx)
      2'd0:    pair_byte = even_pix[11:4];
      2'd1:    pair_byte = {even_pix[3:0], odd_pix[3:0]};
      default: pair_byte = odd_pix[11:4];
    endcase
  end

  always_comb begin
    read_data = 8'h00;
    if (page == PAGE_2) begin
      unique case (cmd_ofs)
        OFS_PIXEL_PAIR_BYTE: read_data = pair_byte;
        OFS_SATURATION_HI:   read_data = sat_detail[15:8];
        OFS_SATURATION_LO:   read_data = sat_detail[7:0];
        OFS_OVERFLOW_HI:     read_data = ovf_detail[15:8];
        OFS_OVERFLOW_LO:     read_data = ovf_detail[7:0];
        OFS_UNDERFLOW_HI:    read_data = unf_detail[15:8];
        OFS_UNDERFLOW_LO:    read_data = unf_detail[7:0];
        OFS_STATUS:          read_data = {7'h00, frame_ready_out};
        default:             read_data = 8'h00;
      endcase
    end else if (page == PAGE_1 && cmd_ofs == OFS_DEFAULT_ADJUST_A) begin
      read_data = default_adjust_a_out;
    end else if (page == PAGE_5 && cmd_ofs == OFS_DEFAULT_ADJUST_B) begin
      read_data = default_adjust_b_out;
    end else if (page == PAGE_4) begin
      unique case (cmd_ofs)
        OFS_DEFAULT_ADJUST_C:  read_data = default_adjust_c_out;
        OFS_MODULATION_SELECT: read_data = modulation_select_out;
        OFS_READOUT_MODE:      read_data = grayscale_imager_setting_out;
        default:               read_data = 8'h00;
      endcase
    end
  end

  // busy answer until idle, then echo or read result
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_word <= WORD_BUSY;
    end else if (!idle) begin
      resp_word <= WORD_BUSY;
    end else if (word_strobe) begin
      resp_word <= is_read ? {cmd, read_data} : rx_word;
    end else if (resp_word == WORD_BUSY) begin
      resp_word <= WORD_NOP;
    end
  end

endmodule : tpr_readout

/* File: tpr_readout_assertions.sv */
// Purpose: concurrent checks on the pixel frame readout ports
// Assumes: sees only the top module ports, two clock domains
// Notes:   each property names its own clock and reset
`timescale 1ns/100ps
module tpr_readout_checker
  import tpr_pkg::*;
#(
  parameter int unsigned STARTUP_LEN = 20
) (
  // system
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  // serial link
  input wire logic       link_sclk_in,
  input wire logic       link_cs_n_in,
  input wire logic       link_miso_out,
  input wire logic       link_miso_oe_out,
  // frame and settings
  input wire logic       frame_done_in,
  input wire logic       frame_ready_out,
  input wire logic [7:0] default_adjust_a_out,
  input wire logic [7:0] default_adjust_b_out,
  input wire logic [7:0] default_adjust_c_out,
  input wire logic [7:0] modulation_select_out,
  input wire logic [7:0] grayscale_imager_setting_out
);
  // ----------------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------------
  sequence s_link_quiet;
    link_cs_n_in [*8];
  endsequence
  a_reset_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !$past(rst_n_in) |-> !frame_ready_out && default_adjust_a_out == 8'h00
      && grayscale_imager_setting_out == 8'h00 && modulation_select_out == 8'h00)
    else $error("settings not cleared by reset");
  a_startup_busy: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !$past(rst_n_in) |-> link_miso_out [*8])
    else $error("busy answer missing after reset");
  a_done_sets_ready: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    frame_done_in |=> frame_ready_out)
    else $error("frame done did not set data ready");
  a_ready_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(frame_ready_out) |-> $past(frame_done_in))
    else $error("data ready rose without frame done");
  a_regs_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_link_quiet |-> $stable({default_adjust_a_out, default_adjust_b_out,
      default_adjust_c_out, modulation_select_out, grayscale_imager_setting_out}))
    else $error("setting changed with link idle");
  a_ready_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_link_quiet ##0 !$past(frame_done_in) |-> $stable(frame_ready_out))
    else $error("data ready changed with link idle");
  a_oe_tracks_cs: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    link_miso_oe_out == !link_cs_n_in)
    else $error("drive enable differs from select");
  a_oe_in_word: assert property (@(posedge link_sclk_in) disable iff (!rst_n_in)
    !link_cs_n_in |-> link_miso_oe_out)
    else $error("serial output not driven in a word");
endmodule : tpr_readout_checker

bind tpr_readout tpr_readout_checker #(.STARTUP_LEN(STARTUP_LEN)) i_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .link_sclk_in(link_sclk_in),
  .link_cs_n_in(link_cs_n_in), .link_miso_out(link_miso_out),
  .link_miso_oe_out(link_miso_oe_out), .frame_done_in(frame_done_in),
  .frame_ready_out(frame_ready_out), .default_adjust_a_out(default_adjust_a_out),
  .default_adjust_b_out(default_adjust_b_out), .default_adjust_c_out(default_adjust_c_out),
  .modulation_select_out(modulation_select_out),
  .grayscale_imager_setting_out(grayscale_imager_setting_out)
);

/* File: tpr_readout_tb.sv */
// Purpose: self-checking bench for the pixel frame readout
// Assumes: host model drives the link, bench drives pixels
// Notes:   startup count shortened to 20 cycles
`timescale 1ns/100ps
module tpr_readout_tb;
  import tpr_pkg::*;
  logic clock_in, rst_n_in, sclk, cs_n, mosi, miso, miso_oe, we, done, ready;
  logic [5:0] addr;
  logic [11:0] data;
  tpr_flag_type flag;
  logic [15:0] resp;
  logic [7:0] adj_a, adj_b, adj_c, mod_sel, gray;
  logic [15:0] sat_d = 16'h1234, ovf_d = 16'h5678, unf_d = 16'h9abc;
  logic [4:0] dofs[6] = '{OFS_SATURATION_HI, OFS_SATURATION_LO, OFS_OVERFLOW_HI,
    OFS_OVERFLOW_LO, OFS_UNDERFLOW_HI, OFS_UNDERFLOW_LO};
  logic [7:0] dval[6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};
  int errors, n_tests;

  // ----------------------------------------------------------------------
  // design, host and helpers
  // ----------------------------------------------------------------------
  tpr_readout #(.STARTUP_LEN(20)) i_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link_sclk_in(sclk),
    .link_cs_n_in(cs_n), .link_mosi_in(mosi), .link_miso_out(miso),
    .link_miso_oe_out(miso_oe), .pixel_we_in(we), .pixel_addr_in(addr),
    .pixel_data_in(data), .pixel_flag_in(flag), .frame_done_in(done),
    .saturation_detail_in(sat_d), .overflow_detail_in(ovf_d),
    .underflow_detail_in(unf_d), .default_adjust_a_out(adj_a),
    .default_adjust_b_out(adj_b), .default_adjust_c_out(adj_c),
    .modulation_select_out(mod_sel), .grayscale_imager_setting_out(gray),
    .frame_ready_out(ready));
  tpr_host_model i_host (.link_sclk_out(sclk), .link_cs_n_out(cs_n),
    .link_mosi_out(mosi), .link_miso_in(miso), .link_miso_oe_in(miso_oe));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  function automatic logic [11:0] exp_pix(input int a, input bit embed);
    if (!embed || (a != 27 && a != 33 && a != 18)) return 12'h010 + 12'(a * 17);
    return a == 27 ? CODE_SATURATED : a == 33 ? CODE_OVERFLOW : CODE_UNDERFLOW;
  endfunction : exp_pix
  function automatic logic [7:0] exp_byte(input int n, input bit embed);
    int ro[8] = '{3, 4, 2, 5, 1, 6, 0, 7};
    logic [11:0] ev, od;
    ev = exp_pix(ro[n / 12] * 8 + (n % 12) / 3 * 2, embed);
    od = exp_pix(ro[n / 12] * 8 + (n % 12) / 3 * 2 + 1, embed);
    case (n % 3)
      0: return ev[11:4];
      1: return {ev[3:0], od[3:0]};
      default: return od[11:4];
    endcase
  endfunction : exp_byte
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] pg, input logic [4:0] ofs, input logic [7:0] val);
    i_host.xfer({CMD_PAGE_MASK | 8'(pg), 8'h00}, resp);
    i_host.xfer({CMD_WRITE_MASK | 8'(ofs), val}, resp);
    chk(resp, {CMD_PAGE_MASK | 8'(pg), 8'h00});
  endtask : wr
  task automatic rd(input logic [2:0] pg, input logic [4:0] ofs);
    i_host.xfer({CMD_PAGE_MASK | 8'(pg), 8'h00}, resp);
    i_host.xfer({CMD_READ_MASK | 8'(ofs), 8'h00}, resp);
    i_host.xfer(WORD_NOP, resp);
  endtask : rd
  task automatic frame(input bit embed);
    for (int a = 0; a < 64; a++) begin
      @(posedge clock_in);
      we <= 1'b1;
      addr <= 6'(a);
      data <= 12'h010 + 12'(a * 17);
      flag <= tpr_flag_type'(2'(a == 27 ? 1 : a == 33 ? 2 : a == 18 ? 3 : 0));
    end
    @(posedge clock_in);
    we <= 1'b0;
    done <= 1'b1;
    @(posedge clock_in);
    done <= 1'b0;
    rd(PAGE_2, OFS_STATUS);
    chk(resp & 16'hff01, {CMD_READ_MASK | 8'(OFS_STATUS), 8'h01});
    for (int n = 0; n <= 96; n++) begin
      i_host.xfer(n < 96 ? 16'h2c00 : WORD_NOP, resp);
      if (n > 0) chk(resp, {8'h2c, exp_byte(n - 1, embed)});
    end
    chk({15'h0000, ready}, 16'h0000);
  endtask : frame
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    we = 1'b0;
    addr = 6'h00;
    data = 12'h000;
    flag = TPR_FLAG_NONE;
    done = 1'b0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    chk({adj_a, adj_b}, 16'h0000);
    chk({adj_c, mod_sel}, 16'h0000);
    chk({gray, 7'h00, ready}, 16'h0000);
    chk({15'h0000, miso}, 16'h0001);
    resp = WORD_BUSY;
    for (int t = 0; t < 30 && resp !== WORD_NOP; t++) i_host.xfer(WORD_NOP, resp);
    if (resp !== WORD_NOP) begin
      errors++;
      stop_test();
    end
    wr(PAGE_1, OFS_DEFAULT_ADJUST_A, 8'ha5);
    chk({8'h00, adj_a}, 16'h00a5);
    wr(PAGE_1, OFS_DEFAULT_ADJUST_A, 8'h00);
    wr(PAGE_5, OFS_DEFAULT_ADJUST_B, 8'h00);
    wr(PAGE_4, OFS_DEFAULT_ADJUST_C, 8'h1f);
    wr(PAGE_4, OFS_MODULATION_SELECT, 8'hc0);
    wr(PAGE_4, OFS_READOUT_MODE, 8'h23);
    wr(PAGE_1, 5'h05, 8'h77);
    chk({adj_a, adj_b}, 16'h0000);
    chk({adj_c, mod_sel}, 16'h1fc0);
    chk({8'h00, gray}, 16'h0023);
    rd(PAGE_4, OFS_READOUT_MODE);
    chk(resp, {CMD_READ_MASK | 8'(OFS_READOUT_MODE), 8'h23});
    rd(PAGE_4, 5'h1f);
    chk(resp, 16'h3f00);
    frame(1'b1);
    // detail words must hold what frame done captured
    @(posedge clock_in);
    {sat_d, ovf_d, unf_d} <= 48'h0f0f_f0f0_5a5a;
    for (int i = 0; i < 6; i++) begin
      rd(PAGE_2, dofs[i]);
      chk(resp, {CMD_READ_MASK | 8'(dofs[i]), dval[i]});
    end
    wr(PAGE_4, OFS_READOUT_MODE, 8'h63);
    frame(1'b0);
    rd(PAGE_2, OFS_SATURATION_HI);
    chk(resp, {CMD_READ_MASK | 8'(OFS_SATURATION_HI), 8'h0f});
    stop_test();
  end
endmodule : tpr_readout_tb
